// File: bench/cst_osc_model.sv
// Behavioural oscillator and external clock sources
`default_nettype none
module cst_osc_model (
    input wire logic [3:0] run, // Per source run enable
    output logic hf_clk, // High-frequency source
    output logic lf_clk, // Low-frequency source
    output logic secondary_osc_clk, // Secondary input pin
    output logic ext_clk // External clock pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        hf_clk = 1'b0;
        lf_clk = 1'b0;
        secondary_osc_clk = 1'b0;
        ext_clk = 1'b0;
    end
    // Stopped source holds its level
    always #50 if (run[0]) hf_clk = ~hf_clk;
    always #200 if (run[1]) lf_clk = ~lf_clk;
    always #500 if (run[2]) secondary_osc_clk = ~secondary_osc_clk;
    always #30 if (run[3]) ext_clk = ~ext_clk;
endmodule : cst_osc_model
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the clock select and trim block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst_n, clock_output_pin_enable, secondary_osc_crystal_mode;
    logic [2:0] reset_source_config, new_source_select, hf_freq_select;
    logic [1:0] ext_power_mode, ext_drive_mode_q;
    logic clock_request_wr, hf_freq_wr, hf_trim_wr, hf_osc_clk, lf_osc_clk;
    logic [3:0] new_divider_select, osc_manual_enable, run;
    logic [5:0] hf_trim_value, hf_trim_target_q, hf_trim_applied_q;
    logic secondary_crystal_in, ext_clock_input_pin;
    logic clock_output_pin_gpio_out, clock_output_pin_gpio_oe, sys_clk_q, switch_pending_q;
    logic [2:0] current_source_q, hf_freq_q;
    logic [3:0] current_divider_q, osc_ready_status_q, osc_enable_q;
    logic lf_timebase_q, mf_500k_q, mf_32k_q, ext_pin_gpio_free_q;
    logic [15:0] ext_limit_khz_q;
    logic clock_output_pin_q, clock_output_pin_oe_q, secondary_osc_amp_en_q;
    logic [31:0] lfsr;
    logic s;
    logic p_hi, p_lo, p_lf;
    int t_hi, t_lo, t_lf;
    int n_mismatch, total_checks, i;
    cst_top dut (.mclk, .rst_n, .reset_source_config, .ext_power_mode,
        .clock_output_pin_enable, .secondary_osc_crystal_mode, .clock_request_wr,
        .new_source_select, .new_divider_select, .hf_freq_wr,
        .hf_freq_select, .hf_trim_wr, .hf_trim_value, .osc_manual_enable,
        .hf_osc_clk, .lf_osc_clk, .secondary_crystal_in,
        .ext_clock_input_pin, .clock_output_pin_gpio_out, .clock_output_pin_gpio_oe, .sys_clk_q,
        .current_source_q, .current_divider_q, .switch_pending_q,
        .osc_ready_status_q, .osc_enable_q, .hf_freq_q, .hf_trim_target_q,
        .hf_trim_applied_q, .lf_timebase_q, .mf_500k_q, .mf_32k_q,
        .ext_drive_mode_q, .ext_limit_khz_q, .ext_pin_gpio_free_q,
        .clock_output_pin_q, .clock_output_pin_oe_q, .secondary_osc_amp_en_q);
    cst_osc_model osc (.run, .hf_clk(hf_osc_clk), .lf_clk(lf_osc_clk),
        .secondary_osc_clk(secondary_crystal_in), .ext_clk(ext_clock_input_pin));
    always #12.5 mclk = ~mclk;
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h0);
    endfunction : nxt
    function automatic logic [15:0] lim(input logic [1:0] m);
        return m == 2'h1 ? 16'd8000 : m == 2'h2 ? 16'd500 : 16'd32000;
    endfunction : lim
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test
    task automatic do_reset(input logic [2:0] strap);
        rst_n = 1'b0;
        reset_source_config = strap;
        repeat (6) @(negedge mclk);
        rst_n = 1'b1;
        repeat (3) @(negedge mclk);
    endtask : do_reset
    task automatic pulse(ref logic wr);
        wr = 1'b1;
        @(negedge mclk);
        wr = 1'b0;
        @(negedge mclk);
    endtask : pulse
    task automatic sw_req(input logic [2:0] src, input logic [3:0] dv);
        logic [2:0] old;
        old = current_source_q;
        new_source_select = src;
        new_divider_select = dv;
        // Pending must show in the cycle right after the request edge
        clock_request_wr = 1'b1;
        @(negedge mclk);
        clock_request_wr = 1'b0;
        chk(16'(switch_pending_q), 16'h1);
        chk(16'(current_source_q), 16'(old));
        for (i = 0; i < 600 && switch_pending_q !== 1'b0; i++) @(negedge mclk);
        chk(16'(current_source_q), 16'(src));
        chk(16'(current_divider_q), 16'(dv > 4'h9 ? 4'h9 : dv));
    endtask : sw_req
    initial begin
        #1_000_000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        {mclk, clock_output_pin_enable, secondary_osc_crystal_mode} = '0;
        {clock_request_wr, hf_freq_wr, hf_trim_wr} = '0;
        {clock_output_pin_gpio_out, clock_output_pin_gpio_oe, ext_power_mode} = '0;
        {new_source_select, new_divider_select, hf_freq_select} = '0;
        {hf_trim_value, osc_manual_enable} = '0;
        run = 4'hf;
        lfsr = 32'h1e40d0b0;
        do_reset(3'h6);
        chk(16'(current_source_q), 16'h6);
        chk(16'(hf_freq_q), 16'(cst_pkg::FRQ_1MHZ));
        chk(16'(hf_trim_target_q), 16'h0);
        do_reset(3'h0);
        chk(16'(current_source_q), 16'h0);
        chk(16'(hf_freq_q), 16'(cst_pkg::FRQ_32MHZ));
        for (int m = 0; m < 3; m++) begin
            ext_power_mode = 2'(m);
            repeat (3) @(negedge mclk);
            chk(ext_limit_khz_q, lim(2'(m)));
            chk(16'(ext_drive_mode_q), 16'(m));
        end
        for (int k = 0; k < 4; k++) begin
            lfsr = nxt(lfsr);
            hf_freq_select = lfsr[2:0];
            pulse(hf_freq_wr);
            chk(16'(hf_freq_q), 16'(lfsr[2:0]));
        end
        lfsr = nxt(lfsr);
        for (int k = 0; k < 3; k++) begin
            hf_trim_value = k == 0 ? 6'h1f : k == 1 ? 6'h20 : lfsr[5:0];
            pulse(hf_trim_wr);
            @(negedge mclk);
            chk(16'(hf_trim_target_q), 16'(hf_trim_value));
            if (k < 2) begin
                chk(16'(hf_trim_applied_q == hf_trim_value), 16'h0);
            end
            repeat (64 * 40 + 10) @(negedge mclk);
            chk(16'(hf_trim_applied_q), 16'(hf_trim_value));
        end
        // Count toggles over a whole multiple of every half period while trimming
        hf_trim_value = hf_trim_value ^ 6'h20;
        pulse(hf_trim_wr);
        {t_hi, t_lo, t_lf} = '0;
        for (int k = 0; k < 5000; k++) begin
            {p_hi, p_lo, p_lf} = {mf_500k_q, mf_32k_q, lf_timebase_q};
            @(negedge mclk);
            t_hi += int'(mf_500k_q != p_hi);
            t_lo += int'(mf_32k_q != p_lo);
            t_lf += int'(lf_timebase_q != p_lf);
        end
        chk(16'(t_hi), 16'(2 * 5000 * 500 / cst_pkg::CLK_KHZ));
        chk(16'(t_lo), 16'(2 * 5000 * 32 / cst_pkg::CLK_KHZ));
        // Model half period 200 ns against 25 ns clock
        chk(16'(t_lf), 16'(5000 * 25 / 200));
        chk(16'(ext_pin_gpio_free_q), 16'h1);
        osc_manual_enable = 4'h8;
        for (i = 0; i < 12 && osc_ready_status_q[3] !== 1'b1; i++)
            @(negedge mclk);
        chk(16'(osc_ready_status_q[3]), 16'h1);
        chk(16'(i < 10), 16'h1);
        chk(16'(ext_pin_gpio_free_q), 16'h0);
        secondary_osc_crystal_mode = 1'b1;
        osc_manual_enable = 4'hc;
        repeat (3) @(negedge mclk);
        chk(16'(secondary_osc_amp_en_q), 16'h1);
        chk(16'(osc_ready_status_q[2]), 16'h0);
        chk(16'(osc_enable_q), 16'hf);
        lfsr = nxt(lfsr);
        sw_req(3'h5, 4'hf);
        sw_req(3'h7, lfsr[3:0]);
        sw_req(3'h0, 4'h1);
        clock_output_pin_enable = 1'b1;
        repeat (3) @(negedge mclk);
        chk(16'(clock_output_pin_oe_q), 16'h1);
        for (int k = 0; k < 8; k++) begin
            s = sys_clk_q;
            @(negedge mclk);
            chk(16'(clock_output_pin_q), 16'(s));
        end
        clock_output_pin_enable = 1'b0;
        clock_output_pin_gpio_out = 1'b1;
        repeat (3) @(negedge mclk);
        chk(16'(clock_output_pin_oe_q), 16'h0);
        chk(16'(clock_output_pin_q), 16'h1);
        run[0] = 1'b0;
        repeat (10) @(negedge mclk);
        s = sys_clk_q;
        repeat (100) @(negedge mclk);
        chk(16'(sys_clk_q), 16'(s));
        run[0] = 1'b1;
        for (i = 0; i < 60 && sys_clk_q === s; i++) @(negedge mclk);
        chk(16'(sys_clk_q), 16'(!s));
        end_of_test();
    end
endmodule : tb
`default_nettype wire

// File: design/cst_edge_sync.sv
// Two-stage synchroniser with rising edge detect for one source pin
`default_nettype none
module cst_edge_sync (
    input wire logic mclk, // System clock
    input wire logic rst_n, // Sync reset
    input wire logic raw, // Asynchronous source level
    output logic lvl, // Synchronised level
    output logic rise // Rising edge pulse
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= raw;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign lvl = sync_q;
    assign rise = sync_q & ~prev_q;
endmodule : cst_edge_sync
`default_nettype wire

// File: design/cst_pkg.sv
// Constants and types for the clock source select and tune block
`default_nettype none
package cst_pkg;
    // Source codes, shared by the reset strap and the run-time request
    localparam logic [2:0] SRC_HF32 = 3'h0;
    localparam logic [2:0] SRC_SECONDARY_OSC = 3'h4;
    localparam logic [2:0] SRC_LF = 3'h5;
    localparam logic [2:0] SRC_HF1 = 3'h6;
    localparam logic [2:0] SRC_EXT = 3'h7;
    // Oscillator index in status and enable vectors
    localparam logic [1:0] OSC_HF = 2'h0;
    localparam logic [1:0] OSC_LF = 2'h1;
    localparam logic [1:0] OSC_SECONDARY_OSC = 2'h2;
    localparam logic [1:0] OSC_EXT = 2'h3;
    localparam int NUM_OSC = 4;
    // High-frequency select codes
    localparam logic [2:0] FRQ_1MHZ = 3'h0;
    localparam logic [2:0] FRQ_32MHZ = 3'h7;
    // Post-divider: code n divides by 2**n, 9 gives 1:512
    localparam logic [3:0] DIV_RST = 4'h0;
    localparam logic [3:0] DIV_MAX = 4'h9;
    localparam logic [5:0] TRIM_RST = 6'h00;
    // External clock power modes and their ceilings in kHz
    localparam logic [1:0] EXT_HIGH = 2'h0;
    localparam logic [1:0] EXT_MED = 2'h1;
    localparam logic [1:0] EXT_LOW = 2'h2;
    localparam logic [15:0] EXT_HIGH_KHZ = 16'd32000;
    localparam logic [15:0] EXT_MED_KHZ = 16'd8000;
    localparam logic [15:0] EXT_LOW_KHZ = 16'd500;
    // Timing
    localparam int CLK_KHZ = 40000;
    localparam int TRIM_STEP_NS = 1000;
    localparam int TRIM_STEP_CYC = (TRIM_STEP_NS * CLK_KHZ + 999999) / 1000000;
    localparam int MF_HI_KHZ = 500;
    localparam int MF_LO_KHZ = 32;
    localparam int MF_HI_HALF = CLK_KHZ / (2 * MF_HI_KHZ);
    localparam int MF_LO_HALF = CLK_KHZ / (2 * MF_LO_KHZ);
    // Source edges counted before an oscillator reports ready
    localparam int SDT_EDGES = 1024;
    localparam int INT_EDGES = 4;
    typedef enum logic [1:0] {
        CST_SW_IDLE = 2'b01,
        CST_SW_WAIT = 2'b10
    } cst_sw_t;
endpackage : cst_pkg
`default_nettype wire

// File: design/cst_ready_ctr.sv
// Start-up edge counter giving one oscillator's ready level
`default_nettype none
module cst_ready_ctr #(
    parameter int EDGES = 4,
    parameter bit BYPASS = 1'b0
) (
    input wire logic mclk, // System clock
    input wire logic rst_n, // Sync reset
    input wire logic en, // Oscillator enabled
    input wire logic rise, // Source edge pulse
    output logic ready // Oscillator running
);
    logic [10:0] cnt_q;
    logic ready_q;

    always_ff @(posedge mclk) begin
        if (!rst_n || !en) begin
            cnt_q <= 11'h000;
            ready_q <= 1'b0;
        end else if (BYPASS) begin
            ready_q <= 1'b1;
        end else if (rise && !ready_q) begin
            if (cnt_q == 11'(EDGES - 1)) begin
                ready_q <= 1'b1;
            end
            cnt_q <= cnt_q + 11'h001;
        end
    end

    assign ready = ready_q;
endmodule : cst_ready_ctr
`default_nettype wire

// File: design/cst_top.sv
// Clock source select, divider, trim and oscillator status logic
// Contract
// - Three external clock power modes: 32 MHz, 8 MHz, 0.5 MHz ceilings.
// - External mode: clock on input pin, output pin is GPIO or clock.
// - External mode skips the start-up delay timer entirely.
// - Fully static: stopped clock freezes state, restart resumes in place.
// - High-frequency oscillator frequency picked by a 3-bit select field.
// - Low-frequency oscillator fixed at 31 kHz, clocks timers and monitor.
// - Strap 110 gives high-frequency at 1 MHz, 000 gives 32 MHz.
// - 4-bit divider select divides by 1 up to 512.
// - Mid-frequency outputs of 500 kHz and 32 kHz from high-frequency block.
// - Trim resets to zero, 6-bit signed, 1Fh maximum, 20h minimum.
// - Trim moves gradually after a write, with no completion flag.
// - Trim leaves the low-frequency oscillator untouched.
// - Internal mode frees input pin; output pin follows its enable bit.
// - Secondary oscillator at 32.768 kHz, crystal or external clock.
// - Separate ready bit for each oscillator, readable any time.
// - Manual enable runs any oscillator; its ready bit sets when running.
// - Keep current clock until requested source reports ready.
`default_nettype none
module cst_top (
    input wire logic mclk, // System clock, 40 MHz
    input wire logic rst_n, // Sync reset, active low
    input wire logic [2:0] reset_source_config, // Reset source strap
    input wire logic [1:0] ext_power_mode, // External clock power mode
    input wire logic clock_output_pin_enable, // Output pin carries clock
    input wire logic secondary_osc_crystal_mode, // Crystal across secondary pins
    input wire logic clock_request_wr, // Request strobe
    input wire logic [2:0] new_source_select, // Requested source
    input wire logic [3:0] new_divider_select, // Requested divider
    input wire logic hf_freq_wr, // Frequency select strobe
    input wire logic [2:0] hf_freq_select, // Frequency select value
    input wire logic hf_trim_wr, // Trim write strobe
    input wire logic [5:0] hf_trim_value, // Trim write value
    input wire logic [3:0] osc_manual_enable, // Manual enable per osc
    input wire logic hf_osc_clk, // High-frequency oscillator
    input wire logic lf_osc_clk, // Low-frequency oscillator
    input wire logic secondary_crystal_in, // Secondary osc input pin
    input wire logic ext_clock_input_pin, // External clock pin
    input wire logic clock_output_pin_gpio_out, // GPIO value for output pin
    input wire logic clock_output_pin_gpio_oe, // GPIO enable for output pin
    output logic sys_clk_q, // Regenerated system clock
    output logic [2:0] current_source_q, // Source in use
    output logic [3:0] current_divider_q, // Divider in use
    output logic switch_pending_q, // Request waiting for ready
    output logic [3:0] osc_ready_status_q, // Ready per oscillator
    output logic [3:0] osc_enable_q, // Enable per oscillator
    output logic [2:0] hf_freq_q, // Frequency select to osc
    output logic [5:0] hf_trim_target_q, // Trim value as written
    output logic [5:0] hf_trim_applied_q, // Trim driven to osc
    output logic lf_timebase_q, // Untrimmed 31 kHz timebase
    output logic mf_500k_q, // Mid-frequency 500 kHz
    output logic mf_32k_q, // Mid-frequency 32 kHz
    output logic [1:0] ext_drive_mode_q, // Pad power mode
    output logic [15:0] ext_limit_khz_q, // External ceiling, kHz
    output logic ext_pin_gpio_free_q, // Input pin free for GPIO
    output logic clock_output_pin_q, // Output pin value
    output logic clock_output_pin_oe_q, // Output pin enable
    output logic secondary_osc_amp_en_q // Crystal amplifier enable
);
    logic [3:0] osc_raw;
    logic [3:0] osc_lvl;
    logic [3:0] osc_rise;
    logic [3:0] osc_rdy;
    cst_pkg::cst_sw_t sw_q;
    logic [2:0] new_src_q;
    logic [3:0] new_div_q;
    logic cfg_done_q;
    logic [8:0] div_cnt_q;
    logic [1:0] cur_idx;
    logic [1:0] new_idx;
    logic sel_rise;
    logic commit;
    logic [5:0] step_cnt_q;
    logic [9:0] mf_hi_cnt_q;
    logic [9:0] mf_lo_cnt_q;

    // Map a source code to its oscillator index
    function automatic logic [1:0] src_idx(input logic [2:0] code);
        unique case (code)
            cst_pkg::SRC_LF: src_idx = cst_pkg::OSC_LF;
            cst_pkg::SRC_SECONDARY_OSC: src_idx = cst_pkg::OSC_SECONDARY_OSC;
            cst_pkg::SRC_EXT: src_idx = cst_pkg::OSC_EXT;
            default: src_idx = cst_pkg::OSC_HF;
        endcase
    endfunction : src_idx

    // Clamp divider code to the largest ratio
    function automatic logic [3:0] clamp_div(input logic [3:0] d);
        clamp_div = (d > cst_pkg::DIV_MAX) ? cst_pkg::DIV_MAX : d;
    endfunction : clamp_div

    assign osc_raw = {ext_clock_input_pin, secondary_crystal_in,
                      lf_osc_clk, hf_osc_clk};
    assign cur_idx = src_idx(current_source_q);
    assign new_idx = src_idx(new_src_q);
    assign sel_rise = osc_rise[cur_idx];

    genvar gi;
    generate
        for (gi = 0; gi < cst_pkg::NUM_OSC; gi++) begin : g_osc
            cst_edge_sync u_sync (
                .mclk(mclk),
                .rst_n(rst_n),
                .raw(osc_raw[gi]),
                .lvl(osc_lvl[gi]),
                .rise(osc_rise[gi])
            );
            cst_ready_ctr #(
                .EDGES(gi == 2 ? cst_pkg::SDT_EDGES : cst_pkg::INT_EDGES),
                .BYPASS(gi == 3)
            ) u_rdy (
                .mclk(mclk),
                .rst_n(rst_n),
                .en(osc_enable_q[gi]),
                .rise(osc_rise[gi]),
                .ready(osc_rdy[gi])
            );
        end
    endgenerate

    // Switch only once target ready; at a low phase
    assign commit = (sw_q == cst_pkg::CST_SW_WAIT) && osc_rdy[new_idx]
                    && !sys_clk_q && !osc_lvl[new_idx];

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sw_q <= cst_pkg::CST_SW_IDLE;
            new_src_q <= cst_pkg::SRC_HF1;
            new_div_q <= cst_pkg::DIV_RST;
        end else begin
            unique case (sw_q)
                cst_pkg::CST_SW_IDLE: begin
                    if (clock_request_wr) begin
                        new_src_q <= new_source_select;
                        new_div_q <= clamp_div(new_divider_select);
                        sw_q <= cst_pkg::CST_SW_WAIT;
                    end
                end
                cst_pkg::CST_SW_WAIT: begin
                    if (clock_request_wr) begin
                        new_src_q <= new_source_select;
                        new_div_q <= clamp_div(new_divider_select);
                    end else if (commit) begin
                        sw_q <= cst_pkg::CST_SW_IDLE;
                    end
                end
                default: sw_q <= cst_pkg::CST_SW_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            switch_pending_q <= 1'b0;
        end else begin
            switch_pending_q <= (sw_q == cst_pkg::CST_SW_WAIT && !commit)
                                || clock_request_wr;
        end
    end

    // Strap captured in the first cycle after reset release
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cfg_done_q <= 1'b0;
            current_source_q <= cst_pkg::SRC_HF1;
            current_divider_q <= cst_pkg::DIV_RST;
        end else if (!cfg_done_q) begin
            cfg_done_q <= 1'b1;
            current_source_q <= reset_source_config;
        end else if (commit && !clock_request_wr) begin
            current_source_q <= new_src_q;
            current_divider_q <= new_div_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hf_freq_q <= cst_pkg::FRQ_1MHZ;
        end else if (!cfg_done_q) begin
            hf_freq_q <= (reset_source_config == cst_pkg::SRC_HF32) ?
                         cst_pkg::FRQ_32MHZ : cst_pkg::FRQ_1MHZ;
        end else if (hf_freq_wr) begin
            hf_freq_q <= hf_freq_select;
        end
    end

    // Post-divider; output moves only on source edges
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sys_clk_q <= 1'b0;
            div_cnt_q <= 9'h000;
        end else if (commit && !clock_request_wr) begin
            sys_clk_q <= 1'b0;
            div_cnt_q <= 9'h000;
        end else if (current_divider_q == cst_pkg::DIV_RST) begin
            sys_clk_q <= osc_lvl[cur_idx];
        end else if (sel_rise) begin
            if (div_cnt_q == 9'((1 << (current_divider_q - 4'h1)) - 1)) begin
                sys_clk_q <= ~sys_clk_q;
                div_cnt_q <= 9'h000;
            end else begin
                div_cnt_q <= div_cnt_q + 9'h001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            osc_enable_q <= 4'h3;
        end else begin
            for (int i = 0; i < cst_pkg::NUM_OSC; i++) begin
                osc_enable_q[i] <= osc_manual_enable[i]
                    || (cur_idx == 2'(i))
                    || (sw_q == cst_pkg::CST_SW_WAIT && new_idx == 2'(i))
                    || (i == 1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            osc_ready_status_q <= 4'h0;
        end else begin
            osc_ready_status_q <= osc_rdy;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hf_trim_target_q <= cst_pkg::TRIM_RST;
        end else if (hf_trim_wr) begin
            hf_trim_target_q <= hf_trim_value;
        end
    end

    // Applied trim walks one step per interval
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hf_trim_applied_q <= cst_pkg::TRIM_RST;
            step_cnt_q <= 6'h00;
        end else if (step_cnt_q == 6'(cst_pkg::TRIM_STEP_CYC - 1)) begin
            step_cnt_q <= 6'h00;
            if ($signed(hf_trim_applied_q) < $signed(hf_trim_target_q)) begin
                hf_trim_applied_q <= hf_trim_applied_q + 6'h01;
            end else if (hf_trim_applied_q != hf_trim_target_q) begin
                hf_trim_applied_q <= hf_trim_applied_q - 6'h01;
            end
        end else begin
            step_cnt_q <= step_cnt_q + 6'h01;
        end
    end

    // Untrimmed low-frequency timebase; fixed 31 kHz
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lf_timebase_q <= 1'b0;
        end else begin
            lf_timebase_q <= osc_lvl[cst_pkg::OSC_LF];
        end
    end

    // Mid-frequency constant clocks, gated by high-freq ready
    always_ff @(posedge mclk) begin
        if (!rst_n || !osc_rdy[cst_pkg::OSC_HF]) begin
            mf_hi_cnt_q <= 10'h000;
            mf_lo_cnt_q <= 10'h000;
            mf_500k_q <= 1'b0;
            mf_32k_q <= 1'b0;
        end else begin
            if (mf_hi_cnt_q == 10'(cst_pkg::MF_HI_HALF - 1)) begin
                mf_hi_cnt_q <= 10'h000;
                mf_500k_q <= ~mf_500k_q;
            end else begin
                mf_hi_cnt_q <= mf_hi_cnt_q + 10'h001;
            end
            if (mf_lo_cnt_q == 10'(cst_pkg::MF_LO_HALF - 1)) begin
                mf_lo_cnt_q <= 10'h000;
                mf_32k_q <= ~mf_32k_q;
            end else begin
                mf_lo_cnt_q <= mf_lo_cnt_q + 10'h001;
            end
        end
    end

    // External power mode and its ceiling
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ext_drive_mode_q <= cst_pkg::EXT_HIGH;
            ext_limit_khz_q <= cst_pkg::EXT_HIGH_KHZ;
        end else begin
            ext_drive_mode_q <= ext_power_mode;
            unique case (ext_power_mode)
                cst_pkg::EXT_MED: ext_limit_khz_q <= cst_pkg::EXT_MED_KHZ;
                cst_pkg::EXT_LOW: ext_limit_khz_q <= cst_pkg::EXT_LOW_KHZ;
                default: ext_limit_khz_q <= cst_pkg::EXT_HIGH_KHZ;
            endcase
        end
    end

    // Output pin clock or GPIO; input pin freed
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            clock_output_pin_q <= 1'b0;
            clock_output_pin_oe_q <= 1'b0;
            ext_pin_gpio_free_q <= 1'b0;
        end else begin
            clock_output_pin_q <= clock_output_pin_enable ?
                                  sys_clk_q : clock_output_pin_gpio_out;
            clock_output_pin_oe_q <= clock_output_pin_enable || clock_output_pin_gpio_oe;
            ext_pin_gpio_free_q <= !osc_enable_q[cst_pkg::OSC_EXT];
        end
    end

    // Crystal amplifier for the secondary oscillator
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            secondary_osc_amp_en_q <= 1'b0;
        end else begin
            secondary_osc_amp_en_q <= osc_enable_q[cst_pkg::OSC_SECONDARY_OSC]
                             && secondary_osc_crystal_mode;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    AST_EXT_BYPASS: assert property (
        $rose(osc_enable_q[3]) |-> ##[1:3] osc_ready_status_q[3])
        else $error("external source not ready at once");
    AST_HOLD_SRC: assert property (
        (sw_q == cst_pkg::CST_SW_WAIT && !osc_rdy[new_idx])
        |=> $stable(current_source_q))
        else $error("source changed before ready");
    AST_NO_RUNT: assert property (
        (cfg_done_q && $past(cfg_done_q) && $changed(current_source_q))
        |-> (!$past(sys_clk_q) && !sys_clk_q))
        else $error("switch on high phase");
    AST_STATIC_HOLD: assert property (
        (current_divider_q != 4'h0 && !sel_rise && !commit)
        |=> $stable(sys_clk_q))
        else $error("clock moved without source edge");
    AST_DIV_TWO: assert property (
        (current_divider_q == 4'h1 && sel_rise && !commit)
        |=> sys_clk_q != $past(sys_clk_q))
        else $error("divide by two missed toggle");
    AST_TRIM_WRITE: assert property (
        hf_trim_wr |=> hf_trim_target_q == $past(hf_trim_value))
        else $error("trim write lost");
    AST_TRIM_STEP: assert property (
        $changed(hf_trim_applied_q) |->
        (hf_trim_applied_q == 6'($past(hf_trim_applied_q) + 6'h01)
         || hf_trim_applied_q == 6'($past(hf_trim_applied_q) - 6'h01)))
        else $error("trim jumped");
    AST_LF_UNTRIMMED: assert property (
        $changed(hf_trim_applied_q) |->
        lf_timebase_q == $past(osc_lvl[cst_pkg::OSC_LF]))
        else $error("timebase disturbed by trim");
    AST_STRAP_HF1: assert property (
        (!cfg_done_q && reset_source_config == cst_pkg::SRC_HF1)
        |=> (hf_freq_q == cst_pkg::FRQ_1MHZ && cur_idx == 2'h0))
        else $error("strap 110 not applied");
    AST_MANUAL_EN: assert property (
        osc_manual_enable[2] |=> osc_enable_q[2])
        else $error("manual enable ignored");

    COV_SWITCH: cover property (commit ##1 sw_q == cst_pkg::CST_SW_IDLE);
    COV_SECONDARY_OSC_RDY: cover property ($rose(osc_ready_status_q[2]));
    COV_TRIM_MOVE: cover property (hf_trim_wr ##[1:100]
                                   $changed(hf_trim_applied_q));
endmodule : cst_top
`default_nettype wire
